// *** hw/rpm_output_mux.sv ***
module rpm_output_mux (
    input  wire logic                                      clk_i,
    input  wire logic                                      reset_n_i,
    input  wire rpm_pkg::rpm_sel_wr_t                      sel_wr_i,
    input  wire logic [rpm_pkg::PIN_IDX_W-1:0]             sel_rd_pin_i,
    input  wire rpm_pkg::rpm_periph_t                      periph_i,
    input  wire logic [rpm_pkg::NUM_PINS-1:0]              port_out_i,
    output logic      [rpm_pkg::NUM_PINS-1:0]              pin_out_o,
    output logic      [rpm_pkg::NUM_PINS-1:0]              pin_remapped_o,
    output logic      [rpm_pkg::SEL_W-1:0]                 sel_rdata_o
);
    import rpm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // decode of one select code; returns {routed, value}
    function automatic logic [1:0] route(input logic [SEL_W-1:0] code,
                                         input rpm_periph_t      p);
        logic [1:0] r;
        r = 2'h0;
        unique case (code)
            SEL_UART_A_TX:  r = {1'b1, p.uart_a_transmit};
            SEL_UART_B_TX:  r = {1'b1, p.uart_b_transmit};
            SEL_SPI_B_DATA: r = {1'b1, p.spi_b_data_out};
            SEL_SPI_B_CLK:  r = {1'b1, p.spi_b_clock_out};
            SEL_SPI_B_SS:   r = {1'b1, p.spi_b_slave_select};
            SEL_CAN_A_TX:   r = {1'b1, p.can_a_transmit};
            SEL_CMP_OUT_A:  r = {1'b1, p.compare_out_a};
            SEL_CMP_OUT_B:  r = {1'b1, p.compare_out_b};
            SEL_CMP_OUT_C:  r = {1'b1, p.compare_out_c};
            SEL_CMP_OUT_D:  r = {1'b1, p.compare_out_d};
            SEL_CMPTR_A:    r = {1'b1, p.comparator_out_a};
            SEL_CMPTR_B:    r = {1'b1, p.comparator_out_b};
            SEL_CMPTR_C:    r = {1'b1, p.comparator_out_c};
            SEL_CMPTR_D:    r = {1'b1, p.comparator_out_d};
            SEL_PWM_SYNC:   r = {1'b1, p.pwm_timebase_sync_out};
            SEL_ENC_CMP:    r = {1'b1, p.encoder_counter_compare_out};
            SEL_REF_CLK:    r = {1'b1, p.reference_clock_out};
            default:        r = 2'h0;  // port code and unassigned codes
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // select field storage, one 6-bit field per pin
    logic [SEL_W-1:0] sel_q [NUM_PINS];
    logic [SEL_W-1:0] sel_d [NUM_PINS];

    // writes touch only the addressed field; no cross-field checks
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            sel_d[i] = sel_q[i];
            if (sel_wr_i.en && (int'(sel_wr_i.pin) == i)) begin
                sel_d[i] = sel_wr_i.code;
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                sel_q[i] <= SEL_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_PINS; i++) begin
                sel_q[i] <= sel_d[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-pin output mux, registered so pins see no decode glitches
    logic [NUM_PINS-1:0] pin_out_d;
    logic [NUM_PINS-1:0] pin_remapped_d;
    logic [SEL_W-1:0]    sel_rdata_d;

    always_comb begin
        logic [1:0] r;
        r = 2'h0;
        for (int i = 0; i < NUM_PINS; i++) begin
            r                 = route(sel_q[i], periph_i);
            pin_remapped_d[i] = r[1];
            pin_out_d[i]      = r[1] ? r[0] : port_out_i[i];
        end
        sel_rdata_d = sel_q[sel_rd_pin_i];
    end

    // one cycle latency from field or source to pin is the price of clean outputs
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_out_o      <= '0;
            pin_remapped_o <= '0;
            sel_rdata_o    <= SEL_RESET;
        end else begin
            pin_out_o      <= pin_out_d;
            pin_remapped_o <= pin_remapped_d;
            sel_rdata_o    <= sel_rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    AST_WRITE_STORES: assert property (
        sel_wr_i.en |=> sel_q[$past(sel_wr_i.pin)] == $past(sel_wr_i.code))
        else $error("select field did not take written code");

    AST_READBACK: assert property (
        sel_rdata_o == $past(sel_q[sel_rd_pin_i]))
        else $error("select readback wrong");

    AST_PORT_DEFAULT: assert property (
        sel_q[0] == SEL_PORT |=> !pin_remapped_o[0] && pin_out_o[0] == $past(port_out_i[0]))
        else $error("port code did not keep default function");

    AST_UART_A: assert property (
        sel_q[1] == SEL_UART_A_TX |=> pin_remapped_o[1]
            && pin_out_o[1] == $past(periph_i.uart_a_transmit))
        else $error("uart a not routed");

    AST_UART_B: assert property (
        sel_q[0] == SEL_UART_B_TX |=> pin_out_o[0] == $past(periph_i.uart_b_transmit))
        else $error("uart b not routed");

    AST_SPI_CLK: assert property (
        sel_q[2] == SEL_SPI_B_CLK |=> pin_out_o[2] == $past(periph_i.spi_b_clock_out))
        else $error("spi clock not routed");

    AST_CAN: assert property (
        sel_q[3] == SEL_CAN_A_TX |=> pin_out_o[3] == $past(periph_i.can_a_transmit))
        else $error("can transmit not routed");

    AST_COMPARE_D: assert property (
        sel_q[4] == SEL_CMP_OUT_D |=> pin_out_o[4] == $past(periph_i.compare_out_d))
        else $error("compare d not routed");

    AST_COMPARATOR_D: assert property (
        sel_q[5] == SEL_CMPTR_D |=> pin_out_o[5] == $past(periph_i.comparator_out_d))
        else $error("comparator d not routed");

    AST_ENC_CMP: assert property (
        sel_q[6] == SEL_ENC_CMP |=> pin_out_o[6] == $past(periph_i.encoder_counter_compare_out))
        else $error("encoder compare not routed");

    AST_REF_CLK: assert property (
        sel_q[7] == SEL_REF_CLK |=> pin_out_o[7] == $past(periph_i.reference_clock_out))
        else $error("reference clock not routed");

    AST_UNASSIGNED: assert property (
        sel_q[0] == 6'h3f |=> !pin_remapped_o[0] && pin_out_o[0] == $past(port_out_i[0]))
        else $error("unassigned code did not fall back to port");

    AST_SHARED_SOURCE: assert property (
        sel_q[0] == sel_q[1] && sel_q[0] == SEL_REF_CLK |=> pin_out_o[0] == pin_out_o[1])
        else $error("shared source differs between pins");

    // remaining codes, spread over pins so every pin is watched by several checks
    AST_SPI_DATA: assert property (
        sel_q[1] == SEL_SPI_B_DATA |=> pin_out_o[1] == $past(periph_i.spi_b_data_out))
        else $error("spi data not routed");

    AST_SPI_SS: assert property (
        sel_q[3] == SEL_SPI_B_SS |=> pin_out_o[3] == $past(periph_i.spi_b_slave_select))
        else $error("spi slave select not routed");

    AST_COMPARE_A: assert property (
        sel_q[5] == SEL_CMP_OUT_A |=> pin_out_o[5] == $past(periph_i.compare_out_a))
        else $error("compare a not routed");

    AST_COMPARE_B: assert property (
        sel_q[6] == SEL_CMP_OUT_B |=> pin_out_o[6] == $past(periph_i.compare_out_b))
        else $error("compare b not routed");

    AST_COMPARE_C: assert property (
        sel_q[7] == SEL_CMP_OUT_C |=> pin_out_o[7] == $past(periph_i.compare_out_c))
        else $error("compare c not routed");

    AST_COMPARATOR_A: assert property (
        sel_q[2] == SEL_CMPTR_A |=> pin_out_o[2] == $past(periph_i.comparator_out_a))
        else $error("comparator a not routed");

    AST_COMPARATOR_B: assert property (
        sel_q[4] == SEL_CMPTR_B |=> pin_out_o[4] == $past(periph_i.comparator_out_b))
        else $error("comparator b not routed");

    AST_COMPARATOR_C: assert property (
        sel_q[0] == SEL_CMPTR_C |=> pin_out_o[0] == $past(periph_i.comparator_out_c))
        else $error("comparator c not routed");

    AST_PWM_SYNC: assert property (
        sel_q[1] == SEL_PWM_SYNC |=> pin_out_o[1] == $past(periph_i.pwm_timebase_sync_out))
        else $error("pwm sync not routed");

    AST_UART_A_HIGH: assert property (
        sel_q[6] == SEL_UART_A_TX |=> pin_out_o[6] == $past(periph_i.uart_a_transmit))
        else $error("uart a not routed on upper pin");

    AST_REMAP_FLAG: assert property (
        sel_q[2] == SEL_CAN_A_TX |=> pin_remapped_o[2])
        else $error("remap flag missing for routed code");

    AST_REF_FLAG: assert property (
        sel_q[5] == SEL_REF_CLK |=> pin_remapped_o[5])
        else $error("remap flag missing for reference clock");

    AST_UNASSIGNED_LOW: assert property (
        sel_q[4] == 6'h02 |=> !pin_remapped_o[4] && pin_out_o[4] == $past(port_out_i[4]))
        else $error("unassigned low code did not fall back to port");

    AST_PORT_DEFAULT_HIGH: assert property (
        sel_q[7] == SEL_PORT |=> !pin_remapped_o[7] && pin_out_o[7] == $past(port_out_i[7]))
        else $error("port code did not keep default function on upper pin");

    // a write to another pin must leave the fields of pins 0 and 7 alone
    AST_FIELD_HOLDS_0: assert property (
        sel_wr_i.en && sel_wr_i.pin != 3'd0 |=> sel_q[0] == $past(sel_q[0]))
        else $error("field of pin 0 changed by a write elsewhere");

    AST_FIELD_HOLDS_7: assert property (
        sel_wr_i.en && sel_wr_i.pin != 3'd7 |=> sel_q[7] == $past(sel_q[7]))
        else $error("field of pin 7 changed by a write elsewhere");

    COV_REMAP: cover property (sel_wr_i.en ##1 pin_remapped_o != '0 ##1 1'b1);
    COV_UNASSIGNED: cover property (sel_q[0] == 6'h3f ##1 !pin_remapped_o[0]);
    COV_SHARE: cover property (sel_q[0] == sel_q[1] && sel_q[0] != SEL_PORT);
    COV_BACK_TO_PORT: cover property (pin_remapped_o[0] ##1 !pin_remapped_o[0]);

endmodule

// *** hw/rpm_pkg.sv ***
package rpm_pkg;

    // sizes
    localparam int unsigned NUM_PINS  = 8;
    localparam int unsigned SEL_W     = 6;
    localparam int unsigned PIN_IDX_W = 3;

    // reset value of every select field
    localparam logic [SEL_W-1:0] SEL_RESET = 6'h00;

    // select codes
    localparam logic [SEL_W-1:0] SEL_PORT        = 6'h00;
    localparam logic [SEL_W-1:0] SEL_UART_A_TX   = 6'h01;
    localparam logic [SEL_W-1:0] SEL_UART_B_TX   = 6'h03;
    localparam logic [SEL_W-1:0] SEL_SPI_B_DATA  = 6'h08;
    localparam logic [SEL_W-1:0] SEL_SPI_B_CLK   = 6'h09;
    localparam logic [SEL_W-1:0] SEL_SPI_B_SS    = 6'h0a;
    localparam logic [SEL_W-1:0] SEL_CAN_A_TX    = 6'h0e;
    localparam logic [SEL_W-1:0] SEL_CMP_OUT_A   = 6'h10;
    localparam logic [SEL_W-1:0] SEL_CMP_OUT_B   = 6'h11;
    localparam logic [SEL_W-1:0] SEL_CMP_OUT_C   = 6'h12;
    localparam logic [SEL_W-1:0] SEL_CMP_OUT_D   = 6'h13;
    localparam logic [SEL_W-1:0] SEL_CMPTR_A     = 6'h18;
    localparam logic [SEL_W-1:0] SEL_CMPTR_B     = 6'h19;
    localparam logic [SEL_W-1:0] SEL_CMPTR_C     = 6'h1a;
    localparam logic [SEL_W-1:0] SEL_PWM_SYNC    = 6'h2d;
    localparam logic [SEL_W-1:0] SEL_ENC_CMP     = 6'h2f;
    localparam logic [SEL_W-1:0] SEL_REF_CLK     = 6'h31;
    localparam logic [SEL_W-1:0] SEL_CMPTR_D     = 6'h32;

    // peripheral outputs feeding the matrix
    typedef struct packed {
        logic uart_a_transmit;
        logic uart_b_transmit;
        logic spi_b_data_out;
        logic spi_b_clock_out;
        logic spi_b_slave_select;
        logic can_a_transmit;
        logic compare_out_a;
        logic compare_out_b;
        logic compare_out_c;
        logic compare_out_d;
        logic comparator_out_a;
        logic comparator_out_b;
        logic comparator_out_c;
        logic comparator_out_d;
        logic pwm_timebase_sync_out;
        logic encoder_counter_compare_out;
        logic reference_clock_out;
    } rpm_periph_t;

    // software write of one select field
    typedef struct packed {
        logic                 en;
        logic [PIN_IDX_W-1:0] pin;
        logic [SEL_W-1:0]     code;
    } rpm_sel_wr_t;

endpackage

// *** tb/rpm_periph_model.sv ***
// peripheral outputs and default port levels seen by the matrix
module rpm_periph_model
    import rpm_pkg::*;
(
    input  wire logic [31:0]          rnd_i,
    output rpm_pkg::rpm_periph_t      periph_o,
    output logic [rpm_pkg::NUM_PINS-1:0] port_out_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // levels are redrawn every cycle so a stale route cannot keep matching by luck
    assign periph_o   = rnd_i[16:0];
    assign port_out_o = rnd_i[24:17];
endmodule

// *** tb/tb_remappable_output_pin_mux.sv ***
module tb_remappable_output_pin_mux;
    timeunit 1ns;
    timeprecision 1ps;
    import rpm_pkg::*;
    // codes in the bit order of the peripheral struct, msb first
    localparam logic [5:0] CODES [17] = '{6'h01, 6'h03, 6'h08, 6'h09, 6'h0a, 6'h0e, 6'h10,
        6'h11, 6'h12, 6'h13, 6'h18, 6'h19, 6'h1a, 6'h32, 6'h2d, 6'h2f, 6'h31};
    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    rpm_sel_wr_t sel_wr_i = '0;
    logic [2:0]  sel_rd_pin_i = '0;
    logic [31:0] rnd = 32'hc87d;
    logic [31:0] part_rnd = '0;
    rpm_periph_t periph;
    logic [7:0]  port_out, pin_out_o, pin_remapped_o, exp_out_q, exp_map_q;
    logic [5:0]  sel_rdata_o, exp_rd_q;
    logic [5:0]  shadow_q [8];
    int          fails = 0;
    int          num_checks = 0;
    int          cyc = 0;
    always #2 clk_i = ~clk_i;
    rpm_periph_model u_periph (.rnd_i(part_rnd), .periph_o(periph), .port_out_o(port_out));
    rpm_output_mux DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .sel_wr_i(sel_wr_i),
        .sel_rd_pin_i(sel_rd_pin_i), .periph_i(periph), .port_out_i(port_out),
        .pin_out_o(pin_out_o), .pin_remapped_o(pin_remapped_o), .sel_rdata_o(sel_rdata_o));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // unlisted codes fall back to the port level
    function automatic logic [1:0] route(input logic [5:0] c, input rpm_periph_t p,
                                         input logic port);
        route = {1'b0, port};
        for (int k = 0; k < 17; k++) if (c === CODES[k]) route = {1'b1, p[16-k]};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // one cycle of stimulus, launched just after the rising edge
    task automatic step(input logic en, input logic [2:0] pin, input logic [5:0] code);
        @(posedge clk_i);
        #1;
        rnd = xs(rnd);
        part_rnd = rnd;
        sel_wr_i = '{en, pin, code};
        sel_rd_pin_i = rnd[27:25];
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // reference: outputs lag the select fields and inputs by one edge
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < 8; i++) shadow_q[i] <= 6'h00;
            {exp_out_q, exp_map_q, exp_rd_q} <= '0;
        end else begin
            for (int i = 0; i < 8; i++) {exp_map_q[i], exp_out_q[i]} <= route(shadow_q[i],
                periph, port_out[i]);
            exp_rd_q <= shadow_q[sel_rd_pin_i];
            if (sel_wr_i.en) shadow_q[sel_wr_i.pin] <= sel_wr_i.code;
        end
    end
    // compare mid-cycle, long after the edge has settled
    always @(negedge clk_i) begin
        cyc++;
        if (cyc > 1) begin
            check(pin_out_o, exp_out_q);
            check(pin_remapped_o, exp_map_q);
            check({2'b00, sel_rdata_o}, {2'b00, exp_rd_q});
        end
        if (cyc == 5000) begin
            fails++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk_i);
        #1;
        reset_n_i = 1'b1;
        // every listed code plus unlisted ones, on every pin, back to back
        for (int p = 0; p < 8; p++) begin
            for (int k = 0; k < 17; k++) step(1'b1, 3'(p), CODES[k]);
            step(1'b1, 3'(p), 6'h02);
            step(1'b1, 3'(p), 6'h3f);
            step(1'b1, 3'(p), 6'h00);
        end
        // one source fanned out to all pins at once
        for (int p = 0; p < 8; p++) step(1'b1, 3'(p), 6'h31);
        repeat (3) step(1'b0, 3'd0, 6'h00);
        check(pin_remapped_o, 8'hff);
        // random mix, mostly assigned codes
        repeat (2000) begin
            step(rnd[28], rnd[31:29], rnd[0] ? CODES[rnd[7:3] % 17] : rnd[13:8]);
        end
        // reset mid-run must clear every field; asserted just after the rising edge
        reset_n_i = 1'b0;
        repeat (3) step(1'b0, 3'd0, 6'h00);
        reset_n_i = 1'b1;
        repeat (40) step(1'b0, 3'd0, 6'h00);
        check(pin_remapped_o, 8'h00);
        check({2'b00, sel_rdata_o}, 8'h00);
        tally_and_finish();
    end
endmodule
